// ==== hw/ncx_exec.sv ====
// Purpose: decode and execute negate, negate with extend, complement, or, idle
// Assumes: apb master from the core; bus_pending_in from core logic, same clock
// Notes: one instruction at a time; operands and flags staged over apb
//
// Operation
// (RL1) size field 00 byte 01 word 10 long
// (RL2) negate group destinations data alterable only
// (RL3) extended address register forms accepted, pc forms refused
// (RL4) extended negate: zero minus operand minus extend
// (RL5) extended negate: carry borrow, extend copies, n, v
// (RL6) extended negate: zero cleared if nonzero, else kept
// (RL7) software sets zero before multi-precision chains
// (RL8) idle instruction changes nothing but program counter
// (RL9) idle waits until pending bus cycles finish
// (RL10) complement inverts every bit of destination
// (RL11) complement: x kept, n z set, v c cleared
// (RL12) or combines source and destination bitwise
// (RL13) or never uses address register operands
// (RL14) or: x kept, n from msb, z, v c cleared
// (RL15) or codes 000-010 result into data register
// (RL16) or codes 100-110 result into effective address
// (RL17) register field picks one of eight data registers
// (RL18) negate: zero minus destination into destination
// (RL19) negate: carry set unless zero, x copies carry
// (RL20) or memory destination only memory alterable modes
// (RL21) data register destination uses register direction encoding
// (RL22) opcode lines 0100, fixed idle word, 1000
// (RL23) byte and word keep upper register bits
//
// Added by the designer: the APB register port and the placing of the registers.

`timescale 1ns/1ps

module ncx_exec
   import ncx_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic pready_out,
   output logic pslverr_out,
   output logic [31:0] prdata_out,
   // core pipeline
   input wire logic bus_pending_in,
   output logic pc_step_out
);

   // -----------------------------------------------------------------
   // registers and state
   // -----------------------------------------------------------------
   logic [15:0] opcode; // latched instruction word
   logic [31:0] ea_operand; // effective address operand value
   logic [31:0] data_register; // data register operand value
   logic [4:0] flags; // x n z v c
   logic [31:0] result; // last written-back value
   logic done; // sticky completion
   logic illegal; // last opcode refused
   logic dest_reg; // last result targets a data register
   ncx_state_type state; // executor state
   ncx_op_type op; // latched operation kind

   // bus decode
   logic setup_phase; // first apb cycle
   logic access_wr; // write takes effect this edge
   logic addr_ok; // mapped address
   logic busy; // instruction in flight

   assign busy = (state != NCX_IDLE);
   assign setup_phase = psel_in & ~penable_in;
   assign access_wr = psel_in & penable_in & pwrite_in;
   assign addr_ok = (paddr_in == NCX_OFS_OPCODE) | (paddr_in == NCX_OFS_EA_OPERAND) |
                    (paddr_in == NCX_OFS_DATA_REG) | (paddr_in == NCX_OFS_FLAGS) |
                    (paddr_in == NCX_OFS_RESULT) | (paddr_in == NCX_OFS_STATUS);

   // zero wait state: answer in the first access cycle
   assign pready_out = psel_in & penable_in;
   assign pslverr_out = psel_in & penable_in & ~addr_ok;

   // -----------------------------------------------------------------
   // decode of a freshly written opcode word
   // -----------------------------------------------------------------
   logic [15:0] w; // word being written
   logic [2:0] w_mode; // ea mode
   logic [2:0] w_reg; // ea register
   logic data_alt; // data alterable destination
   logic mem_alt; // memory alterable destination
   logic data_src; // data addressing source
   ncx_op_type next_op; // decoded kind, none when refused

   assign w = pwdata_in[15:0];
   assign w_mode = w[5:3];
   assign w_reg = w[2:0];

   always_comb begin
      // mode 110 covers indexed and the extended address register forms;
      // the pc-relative forms live under 111 and are refused as destinations, accepted as or sources
      data_alt = (w_mode != NCX_MODE_AREG) & ((w_mode != NCX_MODE_EXT) |
                 (w_reg == NCX_EXT_ABS_W) | (w_reg == NCX_EXT_ABS_L)); // see (RL2) see (RL3)
      mem_alt = data_alt & (w_mode != NCX_MODE_DREG); // see (RL20)
      data_src = (w_mode != NCX_MODE_AREG) &
                 ((w_mode != NCX_MODE_EXT) | (w_reg <= NCX_EXT_IMM)); // see (RL13)
      next_op = NCX_OP_NONE;
      if (w == NCX_IDLE_WORD) begin // see (RL22)
         next_op = NCX_OP_IDLE;
      end else if (w[15:12] == NCX_LINE_MISC && w[7:6] != 2'h3 && data_alt) begin // see (RL1)
         if (w[11:8] == NCX_SUB_NEG) begin
            next_op = NCX_OP_NEG;
         end else if (w[11:8] == NCX_SUB_EXT_NEG) begin
            next_op = NCX_OP_EXTENDED_SUBTRACT_FROM_ZERO_OP;
         end else if (w[11:8] == NCX_SUB_NOT) begin
            next_op = NCX_OP_NOT;
         end
      end else if (w[15:12] == NCX_LINE_OR && w[7:6] != 2'h3) begin
         // opmode bit 8 picks direction; bits 7-6 are the size
         if (!w[8] && data_src) begin // see (RL15)
            next_op = NCX_OP_OR;
         end else if (w[8] && mem_alt) begin // see (RL16) see (RL21)
            next_op = NCX_OP_OR;
         end
      end
   end

   logic opcode_wr; // opcode write accepted
   assign opcode_wr = access_wr & (paddr_in == NCX_OFS_OPCODE) & ~busy;

   // -----------------------------------------------------------------
   // executor state machine
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         state <= NCX_IDLE;
         op <= NCX_OP_NONE;
      end else begin
         unique case (state)
            NCX_IDLE: begin
               if (opcode_wr) begin
                  op <= next_op;
                  if (next_op == NCX_OP_IDLE) begin
                     state <= NCX_WAIT_BUS;
                  end else if (next_op != NCX_OP_NONE) begin
                     state <= NCX_EXEC;
                  end
               end
            end
            NCX_EXEC: begin
               state <= NCX_IDLE;
            end
            NCX_WAIT_BUS: begin
               // hold the pipeline until all earlier bus cycles drain
               if (!bus_pending_in) begin // see (RL9)
                  state <= NCX_IDLE;
               end
            end
         endcase
      end
   end

   // opcode latch
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         opcode <= 16'h0000;
      end else if (opcode_wr) begin
         opcode <= w;
      end
   end

   // -----------------------------------------------------------------
   // operand selection and arithmetic
   // -----------------------------------------------------------------
   logic [1:0] size; // operation size
   logic [31:0] mask; // sized lanes
   logic [31:0] dst; // destination original
   logic [31:0] src; // or source
   logic [31:0] raw; // unsized result
   logic [31:0] sized_res; // result masked to size
   logic [31:0] next_result; // merged write-back value
   logic to_dreg; // destination is a data register
   logic dm; // destination msb
   logic rm; // result msb
   logic rz; // sized result zero
   logic [4:0] next_flags; // flags after execution

   assign size = opcode[7:6];

   always_comb begin
      unique case (size) // see (RL1)
         NCX_SIZE_BYTE: mask = 32'h0000_00ff;
         NCX_SIZE_WORD: mask = 32'h0000_ffff;
         default: mask = 32'hffff_ffff;
      endcase
   end

   always_comb begin
      // or with opmode bit 8 clear writes the register field's data register
      to_dreg = (op == NCX_OP_OR) ? ~opcode[8] : (opcode[5:3] == NCX_MODE_DREG);
      dst = ((op == NCX_OP_OR) && !opcode[8]) ? data_register : ea_operand; // see (RL17)
      src = ((op == NCX_OP_OR) && !opcode[8]) ? ea_operand : data_register;
      unique case (op)
         NCX_OP_NEG: raw = 32'h0000_0000 - dst; // see (RL18)
         NCX_OP_EXTENDED_SUBTRACT_FROM_ZERO_OP: raw = 32'h0000_0000 - dst - {31'h0, flags[NCX_FLG_X]}; // see (RL4)
         NCX_OP_NOT: raw = ~dst; // see (RL10)
         NCX_OP_OR: raw = src | dst; // see (RL12)
         default: raw = dst;
      endcase
      sized_res = raw & mask;
      // a register keeps the lanes above the size; memory sees sized data
      next_result = to_dreg ? (sized_res | (dst & ~mask)) : sized_res; // see (RL23)
   end

   always_comb begin
      unique case (size)
         NCX_SIZE_BYTE: begin
            dm = dst[7];
            rm = raw[7];
         end
         NCX_SIZE_WORD: begin
            dm = dst[15];
            rm = raw[15];
         end
         default: begin
            dm = dst[31];
            rm = raw[31];
         end
      endcase
      rz = (sized_res == 32'h0000_0000);
      next_flags = flags;
      unique case (op)
         NCX_OP_NEG: begin
            next_flags[NCX_FLG_C] = ~rz; // see (RL19)
            next_flags[NCX_FLG_X] = ~rz;
            next_flags[NCX_FLG_N] = rm;
            next_flags[NCX_FLG_Z] = rz;
            next_flags[NCX_FLG_V] = dm & rm;
         end
         NCX_OP_EXTENDED_SUBTRACT_FROM_ZERO_OP: begin
            // borrow out of zero minus operand minus extend
            next_flags[NCX_FLG_C] = dm | rm; // see (RL5)
            next_flags[NCX_FLG_X] = dm | rm;
            next_flags[NCX_FLG_N] = rm;
            next_flags[NCX_FLG_V] = dm & rm;
            // zero only ever falls, so a chain reports all-zero at its end
            if (!rz) begin // see (RL6) see (RL7)
               next_flags[NCX_FLG_Z] = 1'b0;
            end
         end
         NCX_OP_NOT, NCX_OP_OR: begin
            next_flags[NCX_FLG_N] = rm; // see (RL11) see (RL14)
            next_flags[NCX_FLG_Z] = rz;
            next_flags[NCX_FLG_V] = 1'b0;
            next_flags[NCX_FLG_C] = 1'b0;
         end
         default: begin
            next_flags = flags; // see (RL8)
         end
      endcase
   end

   // -----------------------------------------------------------------
   // software-written operand registers
   // -----------------------------------------------------------------
   // writes are refused while busy so operands stay stable mid-instruction
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         ea_operand <= NCX_RST_WORD;
         data_register <= NCX_RST_WORD;
      end else if (access_wr && !busy) begin
         if (paddr_in == NCX_OFS_EA_OPERAND) begin
            ea_operand <= pwdata_in;
         end
         if (paddr_in == NCX_OFS_DATA_REG) begin
            data_register <= pwdata_in;
         end
      end
   end

   // flags: software seeds them, execution updates them
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         flags <= NCX_RST_FLAGS;
      end else if (state == NCX_EXEC) begin
         flags <= next_flags;
      end else if (access_wr && !busy && paddr_in == NCX_OFS_FLAGS) begin
         flags <= pwdata_in[4:0];
      end
   end

   // result and destination kind
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         result <= NCX_RST_WORD;
         dest_reg <= 1'b0;
      end else if (state == NCX_EXEC) begin
         result <= next_result;
         dest_reg <= to_dreg;
      end
   end

   // -----------------------------------------------------------------
   // completion status and program counter step
   // -----------------------------------------------------------------
   logic finish; // instruction completes this edge
   assign finish = (state == NCX_EXEC) | ((state == NCX_WAIT_BUS) & ~bus_pending_in);

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         done <= 1'b0;
         illegal <= 1'b0;
         pc_step_out <= 1'b0;
      end else begin
         pc_step_out <= finish; // see (RL8)
         if (opcode_wr) begin
            // a refused word completes at once and flags the fault
            done <= (next_op == NCX_OP_NONE);
            illegal <= (next_op == NCX_OP_NONE);
         end else if (finish) begin
            done <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // read data, captured in the setup cycle
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         prdata_out <= NCX_RST_WORD;
      end else if (setup_phase) begin
         unique case (paddr_in)
            NCX_OFS_OPCODE: prdata_out <= {16'h0000, opcode};
            NCX_OFS_EA_OPERAND: prdata_out <= ea_operand;
            NCX_OFS_DATA_REG: prdata_out <= data_register;
            NCX_OFS_FLAGS: prdata_out <= {27'h0, flags};
            NCX_OFS_RESULT: prdata_out <= result;
            NCX_OFS_STATUS: prdata_out <= {25'h0, dest_reg, opcode[11:9], illegal, done, busy};
            default: prdata_out <= NCX_RST_WORD;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_idle_flags_kept: assert property (@(posedge clk_in) disable iff (!resetn_in) // see (RL8)
      (state == NCX_WAIT_BUS) |=> $stable(flags) && $stable(result))
      else $error("idle instruction changed flags or result");

   a_idle_waits_bus: assert property (@(posedge clk_in) disable iff (!resetn_in) // see (RL9)
      (state == NCX_WAIT_BUS && bus_pending_in) |=> !pc_step_out && state == NCX_WAIT_BUS)
      else $error("idle instruction finished with bus cycles pending");

   a_not_clears_vc: assert property (@(posedge clk_in) disable iff (!resetn_in) // see (RL11)
      (state == NCX_EXEC && op == NCX_OP_NOT) |=>
      !flags[NCX_FLG_V] && !flags[NCX_FLG_C] && flags[NCX_FLG_X] == $past(flags[NCX_FLG_X]))
      else $error("complement flags wrong");

   a_or_zero_flag: assert property (@(posedge clk_in) disable iff (!resetn_in) // see (RL14)
      (state == NCX_EXEC && op == NCX_OP_OR) |=>
      flags[NCX_FLG_Z] == ((result & $past(mask)) == 32'h0) && !flags[NCX_FLG_C])
      else $error("or zero or carry flag wrong");

   a_extended_subtract_from_zero_op_zero_sticky: assert property (@(posedge clk_in) disable iff (!resetn_in) // see (RL6)
      (state == NCX_EXEC && op == NCX_OP_EXTENDED_SUBTRACT_FROM_ZERO_OP && rz) |=>
      flags[NCX_FLG_Z] == $past(flags[NCX_FLG_Z]))
      else $error("extended negate touched zero on zero result");

   a_neg_carry_x: assert property (@(posedge clk_in) disable iff (!resetn_in) // see (RL19)
      (state == NCX_EXEC && op == NCX_OP_NEG) |=>
      flags[NCX_FLG_C] == ((result & $past(mask)) != 32'h0) &&
      flags[NCX_FLG_X] == flags[NCX_FLG_C])
      else $error("negate carry or extend wrong");

   a_areg_refused: assert property (@(posedge clk_in) disable iff (!resetn_in) // see (RL13)
      (opcode_wr && w[15:12] == NCX_LINE_OR && w_mode == NCX_MODE_AREG) |=>
      illegal && done && state == NCX_IDLE)
      else $error("or accepted an address register operand");

   a_byte_upper_kept: assert property (@(posedge clk_in) disable iff (!resetn_in) // see (RL23)
      (state == NCX_EXEC && to_dreg && size == NCX_SIZE_BYTE) |=>
      result[31:8] == $past(dst[31:8]))
      else $error("byte operation disturbed upper register bits");

   a_exec_one_cycle: assert property (@(posedge clk_in) disable iff (!resetn_in) // see (RL4)
      (opcode_wr && next_op == NCX_OP_EXTENDED_SUBTRACT_FROM_ZERO_OP) |=> state == NCX_EXEC ##1 pc_step_out && done)
      else $error("extended negate did not complete in one cycle");

endmodule : ncx_exec

// ==== hw/ncx_pkg.sv ====
// Purpose: shared constants for the negate / complement / or / idle executor
// Assumes: apb register map, 32-bit data, one aligned word per register
// Notes: condition flags kept in a five-bit word, extend at the top

package ncx_pkg;

   // -----------------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] NCX_OFS_OPCODE = 8'h00; // write starts an instruction
   localparam logic [7:0] NCX_OFS_EA_OPERAND = 8'h04; // effective address operand
   localparam logic [7:0] NCX_OFS_DATA_REG = 8'h08; // data register operand
   localparam logic [7:0] NCX_OFS_FLAGS = 8'h0c; // condition flags
   localparam logic [7:0] NCX_OFS_RESULT = 8'h10; // written-back value
   localparam logic [7:0] NCX_OFS_STATUS = 8'h14; // block state

   // -----------------------------------------------------------------
   // condition flag bit positions
   // -----------------------------------------------------------------
   localparam int NCX_FLG_C = 0;
   localparam int NCX_FLG_V = 1;
   localparam int NCX_FLG_Z = 2;
   localparam int NCX_FLG_N = 3;
   localparam int NCX_FLG_X = 4;

   // -----------------------------------------------------------------
   // status bit positions
   // -----------------------------------------------------------------
   localparam int NCX_STS_BUSY = 0;
   localparam int NCX_STS_DONE = 1;
   localparam int NCX_STS_ILLEGAL = 2;
   localparam int NCX_STS_REG_LO = 3; // opcode bits 11-9; the data register number for or
   localparam int NCX_STS_DEST_REG = 6; // result goes to a data register

   // -----------------------------------------------------------------
   // opcode patterns and field codes
   // -----------------------------------------------------------------
   localparam logic [3:0] NCX_LINE_MISC = 4'h4;
   localparam logic [3:0] NCX_LINE_OR = 4'h8;
   localparam logic [3:0] NCX_SUB_EXT_NEG = 4'h0;
   localparam logic [3:0] NCX_SUB_NEG = 4'h4;
   localparam logic [3:0] NCX_SUB_NOT = 4'h6;
   localparam logic [15:0] NCX_IDLE_WORD = 16'h4e71;
   localparam logic [1:0] NCX_SIZE_BYTE = 2'h0;
   localparam logic [1:0] NCX_SIZE_WORD = 2'h1;
   localparam logic [1:0] NCX_SIZE_LONG = 2'h2;
   localparam logic [2:0] NCX_MODE_DREG = 3'h0;
   localparam logic [2:0] NCX_MODE_AREG = 3'h1;
   localparam logic [2:0] NCX_MODE_IDX = 3'h6;
   localparam logic [2:0] NCX_MODE_EXT = 3'h7;
   localparam logic [2:0] NCX_EXT_ABS_W = 3'h0;
   localparam logic [2:0] NCX_EXT_ABS_L = 3'h1;
   localparam logic [2:0] NCX_EXT_IMM = 3'h4;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [31:0] NCX_RST_WORD = 32'h0000_0000;
   localparam logic [4:0] NCX_RST_FLAGS = 5'h00;

   // executor states
   typedef enum logic [1:0] {NCX_IDLE, NCX_EXEC, NCX_WAIT_BUS} ncx_state_type;

   // decoded operation kinds
   typedef enum logic [2:0] {
      NCX_OP_NONE, NCX_OP_NEG, NCX_OP_EXTENDED_SUBTRACT_FROM_ZERO_OP, NCX_OP_NOT, NCX_OP_OR, NCX_OP_IDLE
   } ncx_op_type;

endpackage : ncx_pkg

// ==== test/ncx_core_model.sv ====
// Purpose: far side model, core pipeline bus traffic and pc steps
// Assumes: same clock and reset as the executor
// Notes: pending stays high for hold_in cycles after a go_in pulse
`timescale 1ns/1ps

module ncx_core_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // bench control
   input wire logic go_in,
   input wire logic [7:0] hold_in,
   // executor side
   input wire logic pc_step_in,
   output logic bus_pending_out,
   output logic [7:0] step_cnt_out
);
   logic [7:0] left; // bus cycles still owed

   // ----------------------------------------------------------
   // outstanding bus cycles, zero hold gives a prompt answer
   // ----------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         left <= 8'h00;
      end else if (go_in) begin
         left <= hold_in;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end
   assign bus_pending_out = (left != 8'h00);

   // counts steps so the bench can tell legal from refused ops
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         step_cnt_out <= 8'h00;
      end else if (pc_step_in) begin
         step_cnt_out <= step_cnt_out + 8'h01;
      end
   end
endmodule : ncx_core_model

// ==== test/tb.sv ====
// Purpose: self-checking bench for the negate / complement / or / idle executor
// Assumes: zero-wait apb slave, one instruction in flight
// Notes: expected values worked out by hand from the operand values
`timescale 1ns/1ps

module tb import ncx_pkg::*;;
   logic clk_in = 1'b0; // core clock
   logic resetn_in, psel, penable, pwrite, pready, pslverr, pend, step, go;
   logic [7:0] paddr, hold, steps, exp_steps;
   logic [31:0] pwdata, prdata, rdat, sts, m;
   logic rerr;
   int error_cnt = 0; // mismatches seen
   int checked = 0; // comparisons made
   int cyc = 0; // hang guard

   always #5 clk_in = ~clk_in;

   ncx_exec i_ncx_exec (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
      .bus_pending_in(pend), .pc_step_out(step));
   ncx_core_model i_ncx_core_model (.clk_in(clk_in), .resetn_in(resetn_in),
      .go_in(go), .hold_in(hold), .pc_step_in(step), .bus_pending_out(pend),
      .step_cnt_out(steps));

   // ----------------------------------------------------------
   // bus and compare tasks
   // ----------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      // no wait-state count assumed; the wait ends when pready rises, or at the hang guard
      do begin
         @(posedge clk_in);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask : rd

   // waits on done; a stuck block runs into the hang guard and fails
   task automatic poll;
      do begin
         apb(1'b0, NCX_OFS_STATUS, 32'h0);
      end while (rdat[NCX_STS_DONE] !== 1'b1);
      sts = rdat;
   endtask : poll

   // operands are staged before the opcode write starts the op
   task automatic exec(input logic [15:0] op, input logic [31:0] ea, input logic [31:0] dr,
         input logic [4:0] fl);
      apb(1'b1, NCX_OFS_EA_OPERAND, ea);
      apb(1'b1, NCX_OFS_DATA_REG, dr);
      apb(1'b1, NCX_OFS_FLAGS, {27'h0, fl});
      apb(1'b1, NCX_OFS_OPCODE, {16'h0, op});
      poll();
   endtask : exec

   // result, flags, and one more pc step
   task automatic res(input logic [31:0] r, input logic [4:0] f);
      rd(NCX_OFS_RESULT, r);
      rd(NCX_OFS_FLAGS, {27'h0, f});
      exp_steps = exp_steps + 8'h01;
      chk({24'h0, steps}, {24'h0, exp_steps});
   endtask : res

   task stop_test;
      $display("counts: checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test

   // a hang counts against the run
   always @(posedge clk_in) begin
      cyc++;
      if (cyc >= 5000) begin
         error_cnt++;
         stop_test();
      end
   end

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      logic [15:0] bad [10];
      bad = '{16'h44c0, 16'h4488, 16'h44ba, 16'h44bc, 16'h4648, 16'h8100,
         16'h8548, 16'h8408, 16'h84c0, 16'h853a};
      resetn_in = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      go = 1'b0;
      hold = 8'h00;
      exp_steps = 8'h00;
      repeat (6) @(posedge clk_in);
      resetn_in <= 1'b1;
      rd(NCX_OFS_FLAGS, 32'h0);
      rd(NCX_OFS_STATUS, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      $display("test done: reset and map");
      exec(16'h4440, 32'habcd_0001, 32'h0, 5'h00);
      res(32'habcd_ffff, 5'h19);
      exec(16'h4410, 32'h1234_5680, 32'h0, 5'h00);
      res(32'h0000_0080, 5'h1b);
      exec(16'h4480, 32'h0, 32'h0, 5'h1b);
      res(32'h0, 5'h04);
      exec(16'h4050, 32'h0, 32'h0, 5'h14);
      res(32'h0000_ffff, 5'h19);
      exec(16'h4010, 32'h0, 32'h0, 5'h04);
      res(32'h0, 5'h04);
      exec(16'h4090, 32'h8000_0000, 32'h0, 5'h04);
      res(32'h8000_0000, 5'h1b);
      $display("test done: negate group");
      exec(16'h4640, 32'h1234_ffff, 32'h0, 5'h13);
      res(32'h1234_0000, 5'h14);
      exec(16'h46b3, 32'h7fff_ffff, 32'h0, 5'h00);
      res(32'h8000_0000, 5'h08);
      $display("test done: complement");
      for (int s = 0; s < 3; s++) begin
         m = (s == 0) ? 32'hff : (s == 1) ? 32'hffff : 32'hffff_ffff;
         exec(16'h8410 | (16'(s) << 6), 32'h8080_8080, 32'h1234_0001, 5'h00);
         res((32'h1234_0001 & ~m) | (32'h92b4_8081 & m), 5'h08);
         chk(sts, 32'h52);
         exec(16'h8510 | (16'(s) << 6), 32'h8080_8080, 32'h1234_0001, 5'h00);
         res(32'h92b4_8081 & m, 5'h08);
         chk(sts, 32'h12);
      end
      exec(16'h8e40, 32'h0, 32'h0, 5'h1f);
      res(32'h0, 5'h14);
      $display("test done: or");
      foreach (bad[i]) begin
         exec(bad[i], 32'h1, 32'h1, 5'h00);
         chk(sts & 32'h7, 32'h6);
      end
      chk({24'h0, steps}, {24'h0, exp_steps});
      $display("test done: refused encodings");
      apb(1'b1, NCX_OFS_FLAGS, 32'h15);
      @(posedge clk_in);
      go <= 1'b1;
      hold <= 8'd30;
      @(posedge clk_in);
      go <= 1'b0;
      apb(1'b1, NCX_OFS_OPCODE, {16'h0, NCX_IDLE_WORD});
      apb(1'b0, NCX_OFS_STATUS, 32'h0);
      chk(rdat & 32'h7, 32'h1);
      apb(1'b1, NCX_OFS_FLAGS, 32'h0);
      poll();
      rd(NCX_OFS_FLAGS, 32'h15);
      rd(NCX_OFS_RESULT, 32'h0);
      exp_steps = exp_steps + 8'h01;
      chk({24'h0, steps}, {24'h0, exp_steps});
      exec(NCX_IDLE_WORD, 32'h5, 32'h5, 5'h0a);
      chk(sts & 32'h7, 32'h2);
      rd(NCX_OFS_FLAGS, 32'h0a);
      exp_steps = exp_steps + 8'h01;
      chk({24'h0, steps}, {24'h0, exp_steps});
      $display("test done: idle instruction");
      stop_test();
   end
endmodule : tb
